// file: rtl/sbx_sub_exec.sv
// execution logic for the two subtract instructions of the core.
// assumes the core offers one instruction per start pulse, supplies the
// working register and bank select, and answers a memory read one cycle later.
//
// Overview of operation
// - literal opcode: literal minus W into W
// - literal op: one word, four-phase cycle
// - file opcode 010111 d a f: f minus W
// - dest bit 0: write W, keep file
// - dest bit 1: write back file register
// - access bit 0: access bank, ignore bank select
// - access bit 1: bank select chooses bank
// - file op: one word, four-phase cycle
// - borrow: carry clear, zero clear, negative follows result sign
// - zero sets zero and carry; positive sets carry
`timescale 1ns/10ps
module sbx_sub_exec
    import sbx_pkg::*;
#(
    parameter logic [7:0] ACCESS_SPLIT_P = sbx_pkg::ACCESS_SPLIT  // access bank split
)(
    input  wire logic                         i_clock,            // core clock, 100 MHz
    input  wire logic                         i_srst,             // synchronous reset, high
    input  wire logic                         i_start,            // instruction offered
    input  wire logic [sbx_pkg::INSTR_W-1:0]  i_instr,            // program word
    input  wire logic [sbx_pkg::DATA_W-1:0]   i_wreg,             // working register value
    input  wire logic [sbx_pkg::BANK_W-1:0]   i_bank_select_reg,  // bank select value
    input  wire logic [sbx_pkg::DATA_W-1:0]   i_mem_rdata,        // file read data
    output logic                              o_busy,             // cycle in progress
    output logic                              o_reject,           // start not taken
    output logic      [sbx_pkg::ADDR_W-1:0]   o_mem_addr,         // resolved file address
    output logic                              o_mem_rd,           // file read strobe
    output logic                              o_mem_we,           // file write strobe
    output logic      [sbx_pkg::DATA_W-1:0]   o_mem_wdata,        // file write data
    output logic                              o_wreg_we,          // working register write
    output logic      [sbx_pkg::DATA_W-1:0]   o_wreg_wdata,       // working register data
    output logic                              o_flags_we,         // status flags update
    output logic                              o_carry,            // carry, no borrow
    output logic                              o_digit_carry,      // digit carry flag
    output logic                              o_zero,             // zero flag
    output logic                              o_negative,         // negative flag
    output logic                              o_overflow_flag     // overflow flag
);
    import sbx_pkg::*;

    // decode helpers, used at accept time and during decode
    function automatic logic f_is_lit(input logic [INSTR_W-1:0] w);
        f_is_lit = (w[LIT_OPC_HI:LIT_OPC_LO] == LIT_OPC);
    endfunction : f_is_lit

    function automatic logic f_is_file(input logic [INSTR_W-1:0] w);
        f_is_file = (w[FILE_OPC_HI:FILE_OPC_LO] == FILE_OPC);
    endfunction : f_is_file

    sbx_phase_t          phase;           // current phase
    logic                go;              // start taken
    logic [INSTR_W-1:0]  instr_r;         // latched program word
    logic                is_file_r;       // decoded: file variant
    logic                dest_w_r;        // decoded: write to working register
    logic [DATA_W-1:0]   lit_r;           // literal operand
    logic [ADDR_W-1:0]   addr_r;          // resolved address
    logic [DATA_W-1:0]   result_r;        // registered difference
    logic [DATA_W-1:0]   minuend;         // operand for the subtractor
    logic [DATA_W-1:0]   diff;            // subtractor output
    logic                c_n;             // carry from subtractor
    logic                dc_n;            // digit carry from subtractor
    logic                z_n;             // zero from subtractor
    logic                n_n;             // negative from subtractor
    logic                ov_n;            // overflow from subtractor
    logic [BANK_W-1:0]   bank;            // chosen bank
    logic [DATA_W-1:0]   faddr;           // file address field

    // start is taken only when idle and the word is one of the two subtracts
    assign go       = i_start && (phase == PH_IDLE) && (f_is_lit(i_instr) || f_is_file(i_instr));
    assign o_reject = i_start && !go;
    assign o_busy   = (phase != PH_IDLE);

    sbx_phase_seq u_seq (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_go    (go),
        .o_phase (phase)
    );

    // latch the word when the start is taken
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            instr_r <= ZERO_WORD;
        end else if (go) begin
            instr_r <= i_instr;
        end
    end

    // q1 decode: variant and destination
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            is_file_r <= 1'b0;
            dest_w_r  <= 1'b0;
        end else if (phase == PH_Q1) begin
            is_file_r <= f_is_file(instr_r);
            // literal form always writes W; file form follows its dest bit
            dest_w_r  <= f_is_lit(instr_r) || (instr_r[DEST_BIT] == DEST_TO_W);
        end
    end

    // bank resolution: access bank split or bank select register
    always_comb begin
        faddr = instr_r[DATA_W-1:0];
        if (instr_r[ACCESS_BIT] == USE_ACCESS) begin
            bank = (faddr < ACCESS_SPLIT_P) ? ACCESS_LO_BNK : ACCESS_HI_BNK;
        end else begin
            bank = i_bank_select_reg;
        end
    end

    // q1 resolves the file address ready for the q2 read
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            addr_r <= ZERO_ADDR;
        end else if (phase == PH_Q1) begin
            addr_r <= {bank, faddr};
        end
    end

    // q2 reads the literal from the word
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            lit_r <= ZERO_BYTE;
        end else if (phase == PH_Q2) begin
            lit_r <= instr_r[DATA_W-1:0];
        end
    end

    // q2 read strobe for the file variant; data return in q3
    assign o_mem_rd   = (phase == PH_Q2) && is_file_r;
    assign o_mem_addr = addr_r;

    // q3 operand choice
    assign minuend = is_file_r ? i_mem_rdata : lit_r;

    sbx_sub_alu #(
        .WIDTH (DATA_W)
    ) u_alu (
        .i_minuend     (minuend),
        .i_subtrahend  (i_wreg),
        .o_diff        (diff),
        .o_carry       (c_n),
        .o_digit_carry (dc_n),
        .o_zero        (z_n),
        .o_negative    (n_n),
        .o_overflow    (ov_n)
    );

    // q3 process: register difference and flags
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            result_r        <= ZERO_BYTE;
            o_carry         <= 1'b0;
            o_digit_carry   <= 1'b0;
            o_zero          <= 1'b0;
            o_negative      <= 1'b0;
            o_overflow_flag <= 1'b0;
        end else if (phase == PH_Q3) begin
            result_r        <= diff;
            o_carry         <= c_n;
            o_digit_carry   <= dc_n;
            o_zero          <= z_n;
            o_negative      <= n_n;
            o_overflow_flag <= ov_n;
        end
    end

    // q4 write to the chosen destination
    assign o_wreg_we    = (phase == PH_Q4) && dest_w_r;
    assign o_mem_we     = (phase == PH_Q4) && !dest_w_r;
    assign o_flags_we   = (phase == PH_Q4);
    assign o_wreg_wdata = result_r;
    assign o_mem_wdata  = result_r;

    // ---- assertions ----
    sequence s_lit_start;
        go && f_is_lit(i_instr);
    endsequence

    sequence s_file_start;
        go && f_is_file(i_instr);
    endsequence

    sequence s_file_to_f;
        go && f_is_file(i_instr) && i_instr[DEST_BIT] != DEST_TO_W;
    endsequence

    property p_lit_to_w;
        logic [DATA_W-1:0] k;
        @(posedge i_clock) disable iff (i_srst)
        (s_lit_start, k = i_instr[DATA_W-1:0]) |->
        ##4 (o_wreg_we && !o_mem_we && o_wreg_wdata == k - $past(i_wreg));
    endproperty
    a_lit_to_w: assert property (p_lit_to_w) else $error("literal result not in W");

    // the literal form never reads or writes data memory
    property p_lit_no_mem;
        @(posedge i_clock) disable iff (i_srst)
        s_lit_start |=> (!o_mem_rd && !o_mem_we) [*4];
    endproperty
    a_lit_no_mem: assert property (p_lit_no_mem) else $error("literal op touched memory");

    property p_one_cycle;
        @(posedge i_clock) disable iff (i_srst)
        go |=> o_busy [*3] ##1 (o_busy && o_flags_we) ##1 !o_busy;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("cycle not four phases");

    // a start offered mid-cycle is turned away, never queued
    property p_busy_reject;
        @(posedge i_clock) disable iff (i_srst)
        (i_start && o_busy) |-> o_reject;
    endproperty
    a_busy_reject: assert property (p_busy_reject) else $error("start taken while busy");

    property p_file_read;
        @(posedge i_clock) disable iff (i_srst)
        s_file_start |-> ##2 o_mem_rd ##1 !o_mem_rd;
    endproperty
    a_file_read: assert property (p_file_read) else $error("file read not in q2");

    property p_dest_w;
        @(posedge i_clock) disable iff (i_srst)
        (go && f_is_file(i_instr) && i_instr[DEST_BIT] == DEST_TO_W)
        |-> ##4 (o_wreg_we && !o_mem_we);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("dest 0 wrote file");

    property p_dest_f;
        logic [DATA_W-1:0] fv;
        @(posedge i_clock) disable iff (i_srst)
        s_file_to_f ##3 (1'b1, fv = i_mem_rdata) |=>
        (o_mem_we && !o_wreg_we && o_mem_wdata == fv - $past(i_wreg, 1));
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("dest 1 did not write file");

    property p_access;
        @(posedge i_clock) disable iff (i_srst)
        (go && f_is_file(i_instr) && i_instr[ACCESS_BIT] == USE_ACCESS && i_instr[DATA_W-1:0] < ACCESS_SPLIT_P)
        |-> ##2 (o_mem_addr[ADDR_W-1:DATA_W] == ACCESS_LO_BNK);
    endproperty
    a_access: assert property (p_access) else $error("access bank not used");

    // upper half of the access bank maps to the top bank
    property p_access_hi;
        @(posedge i_clock) disable iff (i_srst)
        (s_file_start ##0 (i_instr[ACCESS_BIT] == USE_ACCESS && i_instr[DATA_W-1:0] >= ACCESS_SPLIT_P))
        |-> ##2 (o_mem_addr[ADDR_W-1:DATA_W] == ACCESS_HI_BNK);
    endproperty
    a_access_hi: assert property (p_access_hi) else $error("upper access bank not used");

    property p_banked;
        logic [BANK_W-1:0] b;
        @(posedge i_clock) disable iff (i_srst)
        (go && f_is_file(i_instr) && i_instr[ACCESS_BIT] != USE_ACCESS) ##1 (1'b1, b = i_bank_select_reg)
        |=> (o_mem_addr[ADDR_W-1:DATA_W] == b && o_mem_rd);
    endproperty
    a_banked: assert property (p_banked) else $error("bank select ignored");

    property p_file_cycle;
        @(posedge i_clock) disable iff (i_srst)
        s_file_start |=> !o_mem_rd ##1 o_mem_rd ##1 !(o_mem_we || o_wreg_we) ##1 (o_mem_we || o_wreg_we);
    endproperty
    a_file_cycle: assert property (p_file_cycle) else $error("file cycle order wrong");

    // a borrow clears carry and zero; negative follows the result sign
    property p_borrow;
        @(posedge i_clock) disable iff (i_srst)
        (phase == PH_Q3 && minuend < i_wreg) |=>
        (!o_carry && !o_zero && o_negative == result_r[SIGN_BIT]);
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow flags wrong");

    // a nonzero difference without borrow keeps carry set and zero clear
    property p_positive;
        @(posedge i_clock) disable iff (i_srst)
        (phase == PH_Q3 && minuend > i_wreg) |=>
        (o_carry && !o_zero && o_negative == result_r[SIGN_BIT]);
    endproperty
    a_positive: assert property (p_positive) else $error("positive flags wrong");

    property p_zero;
        @(posedge i_clock) disable iff (i_srst)
        o_flags_we && o_zero |-> (o_carry && !o_negative && o_digit_carry && o_wreg_wdata == ZERO_BYTE);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flags wrong");

    property p_overflow;
        @(posedge i_clock) disable iff (i_srst)
        (phase == PH_Q3) |=> o_overflow_flag ==
            (($past(minuend[SIGN_BIT]) != $past(i_wreg[SIGN_BIT])) &&
             (result_r[SIGN_BIT] != $past(minuend[SIGN_BIT])));
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag wrong");

    // digit carry is set when the low nibble needs no borrow
    property p_digit_carry;
        @(posedge i_clock) disable iff (i_srst)
        (phase == PH_Q3) |=> o_digit_carry == ($past(minuend[NIB_HI:0]) >= $past(i_wreg[NIB_HI:0]));
    endproperty
    a_digit_carry: assert property (p_digit_carry) else $error("digit carry wrong");

endmodule : sbx_sub_exec

// file: inc/sbx_pkg.sv
// package for the subtract execution block: encodings, field positions,
// access bank split and the phase enumeration.
// assumes a 16-bit instruction word and an 8-bit data path with 4-bit bank select.
package sbx_pkg;

    // instruction word layout
    localparam int unsigned INSTR_W       = 16;           // program word width
    localparam int unsigned DATA_W        = 8;            // data path width
    localparam int unsigned BANK_W        = 4;            // bank select width
    localparam int unsigned ADDR_W        = 12;           // bank plus file address
    localparam int unsigned LIT_OPC_HI    = 15;           // literal opcode upper bit
    localparam int unsigned LIT_OPC_LO    = 8;            // literal opcode lower bit
    localparam int unsigned FILE_OPC_HI   = 15;           // file opcode upper bit
    localparam int unsigned FILE_OPC_LO   = 10;           // file opcode lower bit
    localparam int unsigned DEST_BIT      = 9;            // destination select bit
    localparam int unsigned ACCESS_BIT    = 8;            // bank access select bit
    localparam int unsigned NIB_HI        = 3;            // top bit of low nibble
    localparam int unsigned SIGN_BIT      = 7;            // sign bit of data byte

    // opcode values
    localparam logic [7:0]  LIT_OPC       = 8'h08;        // literal minus working register
    localparam logic [5:0]  FILE_OPC      = 6'h17;        // file minus working register

    // field values
    localparam logic        DEST_TO_W     = 1'b0;         // destination is working register
    localparam logic        USE_ACCESS    = 1'b0;         // resolve in the access bank

    // access bank split: low half maps to bank 0, high half to the top bank
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;        // first address of upper half
    localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;         // bank for the lower half
    localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;         // bank for the upper half
    localparam logic [7:0]  ZERO_BYTE     = 8'h00;        // cleared data byte
    localparam logic [15:0] ZERO_WORD     = 16'h0000;     // cleared instruction word
    localparam logic [11:0] ZERO_ADDR     = 12'h000;      // cleared address

    // instruction cycle phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } sbx_phase_t;

endpackage : sbx_pkg

// file: rtl/sbx_phase_seq.sv
// four-phase instruction cycle sequencer.
// assumes a start pulse only while idle; runs q1..q4 once per start.
`timescale 1ns/10ps
module sbx_phase_seq
    import sbx_pkg::*;
(
    input  wire logic              i_clock,   // core clock
    input  wire logic              i_srst,    // synchronous reset, high
    input  wire logic              i_go,      // accepted start, one cycle
    output sbx_pkg::sbx_phase_t    o_phase    // current phase
);
    sbx_phase_t phase_r;   // phase register
    sbx_phase_t phase_nxt; // next phase

    // next phase: one pass through the four phases per start
    always_comb begin
        case (phase_r)
            PH_IDLE: phase_nxt = i_go ? PH_Q1 : PH_IDLE;
            PH_Q1:   phase_nxt = PH_Q2;
            PH_Q2:   phase_nxt = PH_Q3;
            PH_Q3:   phase_nxt = PH_Q4;
            PH_Q4:   phase_nxt = PH_IDLE;
            default: phase_nxt = PH_IDLE;
        endcase
    end

    // phase register
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            phase_r <= PH_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    assign o_phase = phase_r;

endmodule : sbx_phase_seq

// file: rtl/sbx_sub_alu.sv
// 8-bit subtractor: minuend minus working register, with status flags.
// assumes purely combinational use; the caller registers the outputs.
`timescale 1ns/10ps
module sbx_sub_alu
    import sbx_pkg::*;
#(
    parameter int unsigned WIDTH = 8                  // data width
)(
    input  wire logic [WIDTH-1:0] i_minuend,          // literal or file value
    input  wire logic [WIDTH-1:0] i_subtrahend,       // working register
    output logic      [WIDTH-1:0] o_diff,             // difference
    output logic                  o_carry,            // high when no borrow
    output logic                  o_digit_carry,      // high when no nibble borrow
    output logic                  o_zero,             // difference is zero
    output logic                  o_negative,         // difference sign
    output logic                  o_overflow          // signed overflow
);
    logic [WIDTH:0] wide; // difference with borrow bit

    // two's complement difference with borrow flags
    always_comb begin
        wide          = {1'b0, i_minuend} - {1'b0, i_subtrahend};
        o_diff        = wide[WIDTH-1:0];
        o_carry       = ~wide[WIDTH];
        o_digit_carry = (i_minuend[NIB_HI:0] >= i_subtrahend[NIB_HI:0]);
        o_zero        = (wide[WIDTH-1:0] == '0);
        o_negative    = wide[WIDTH-1];
        o_overflow    = (i_minuend[WIDTH-1] != i_subtrahend[WIDTH-1]) &&
                        (wide[WIDTH-1] != i_minuend[WIDTH-1]);
    end

endmodule : sbx_sub_alu

// file: test/sbx_core_model.sv
// data memory model of the core standing beside the subtract block.
// assumes one-cycle read and write strobes; read data are wanted in the next cycle.
`timescale 1ns/10ps
module sbx_core_model
    import sbx_pkg::*;
(
    input  wire logic                        i_clock,      // core clock
    input  wire logic                        i_mem_rd,     // read strobe
    input  wire logic                        i_mem_we,     // write strobe
    input  wire logic [sbx_pkg::ADDR_W-1:0]  i_mem_addr,   // bank and file address
    input  wire logic [sbx_pkg::DATA_W-1:0]  i_mem_wdata,  // write data
    output logic      [sbx_pkg::DATA_W-1:0]  o_mem_rdata   // read data
);
    logic [DATA_W-1:0] mem [0:4095];  // banked file registers, preloaded by the bench

    initial o_mem_rdata = 8'h00;

    // answer a read next cycle; otherwise toggle so stale data never looks valid
    always @(posedge i_clock) begin
        if (i_mem_rd) begin
            o_mem_rdata <= mem[i_mem_addr];
        end else begin
            o_mem_rdata <= ~o_mem_rdata;
        end
    end

    // store the difference written back in the write phase
    always @(posedge i_clock) begin
        if (i_mem_we) begin
            mem[i_mem_addr] <= i_mem_wdata;
        end
    end
endmodule : sbx_core_model

// file: test/sbx_sub_exec_test.sv
// self-checking bench for the subtract execution block.
// assumes the core model answers file reads; the bench plays decode and w register.
`timescale 1ns/10ps
module sbx_sub_exec_test;
    import sbx_pkg::*;

    logic        clock = 1'b0;                   // 100 MHz core clock
    logic        srst = 1'b1;                    // synchronous reset
    logic        start = 1'b0;                   // instruction offered
    logic [15:0] instr = 16'h0000;               // program word
    logic [7:0]  wreg = 8'h00;                   // working register
    logic [3:0]  bank_select_reg = 4'h0;                     // bank select
    logic [7:0]  rdata;                          // file read data
    logic        busy, reject, mem_rd, mem_we;   // status and strobes
    logic        wreg_we, flags_we;              // write strobes
    logic [11:0] mem_addr;                       // resolved address
    logic [7:0]  mem_wdata, wreg_wdata;          // result data
    logic        carry, dc, zero, negative, ov;  // flags
    int          mismatches = 0;                 // failed compares
    int          tests_run = 0;                  // compares made
    int          cycles = 0;                     // timeout counter

    // table of operations: word, w, bank select, file value, second start
    logic [15:0] ins_t [9] = '{16'h0802, 16'h0802, 16'h0802, 16'h0880, 16'h087F,
                               16'h5E10, 16'h5C90, 16'h5F45, 16'h5DA7};
    logic [7:0]  w_t [9]   = '{8'h01, 8'h02, 8'h03, 8'h01, 8'hFF, 8'h02, 8'h02, 8'h02, 8'h7F};
    logic [3:0]  bs_t [9]  = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'h5, 4'h3, 4'hA};
    logic [7:0]  fv_t [9]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h02, 8'h01, 8'h80};
    logic        dbl_t [9] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

    always #5 clock = ~clock;

    sbx_sub_exec i_dut (
        .i_clock(clock), .i_srst(srst), .i_start(start), .i_instr(instr), .i_wreg(wreg),
        .i_bank_select_reg(bank_select_reg), .i_mem_rdata(rdata), .o_busy(busy), .o_reject(reject),
        .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .o_mem_we(mem_we), .o_mem_wdata(mem_wdata),
        .o_wreg_we(wreg_we), .o_wreg_wdata(wreg_wdata), .o_flags_we(flags_we), .o_carry(carry),
        .o_digit_carry(dc), .o_zero(zero), .o_negative(negative), .o_overflow_flag(ov)
    );

    sbx_core_model i_core (
        .i_clock(clock), .i_mem_rd(mem_rd), .i_mem_we(mem_we), .i_mem_addr(mem_addr),
        .i_mem_wdata(mem_wdata), .o_mem_rdata(rdata)
    );

    // compare one value against its expectation
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // print counts and verdict, then end the run
    task automatic stop_test();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    // run one subtract, checking each phase; dbl offers a second start while busy
    task automatic exec(input logic [15:0] ins, input logic [7:0] w, input logic [3:0] bs,
                        input logic [7:0] fv, input logic dbl);
        logic        is_f;  // file variant
        logic        to_f;  // result goes to the file
        logic [11:0] ea;    // expected address
        logic [7:0]  m;     // minuend
        logic [7:0]  d;     // difference
        is_f = (ins[15:10] == 6'b01_0111);
        to_f = is_f && ins[9];
        ea = ins[8] ? {bs, ins[7:0]} : {(ins[7:0] < 8'h80) ? 4'h0 : 4'hF, ins[7:0]};
        if (is_f) i_core.mem[ea] = fv;
        m = is_f ? fv : ins[7:0];
        d = m - w;
        @(posedge clock);
        start <= 1'b1;
        instr <= ins;
        wreg <= w;
        bank_select_reg <= bs;
        @(posedge clock);
        start <= dbl;
        #1;
        check(busy, 1'b1);
        check(reject, dbl);
        @(posedge clock);
        start <= 1'b0;
        #1;
        check(mem_rd, is_f);
        if (is_f) check(mem_addr, ea);
        @(posedge clock);
        #1;
        check({mem_rd, mem_we, wreg_we, flags_we}, 4'h0);
        @(posedge clock);
        #1;
        check({mem_we, wreg_we, flags_we}, {to_f, !to_f, 1'b1});
        check(to_f ? mem_wdata : wreg_wdata, d);
        check({carry, zero, negative}, {m >= w, d == 8'h00, d[7]});
        check({ov, dc}, {(m[7] != w[7]) && (d[7] != m[7]), m[3:0] >= w[3:0]});
        @(posedge clock);
        #1;
        check(busy, 1'b0);
        if (is_f) check(i_core.mem[ea], to_f ? d : fv);
    endtask : exec

    // offer a word that is no subtract while idle
    task automatic refuse(input logic [15:0] ins);
        @(posedge clock);
        start <= 1'b1;
        instr <= ins;
        #1;
        check(reject, 1'b1);
        @(posedge clock);
        start <= 1'b0;
        #1;
        check(busy, 1'b0);
    endtask : refuse

    // cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        #1;
        check({busy, mem_rd, mem_we, wreg_we, flags_we}, 5'h00);
        for (int i = 0; i < 9; i++) begin
            exec(ins_t[i], w_t[i], bs_t[i], fv_t[i], dbl_t[i]);
        end
        refuse(16'h0F00);
        refuse(16'h5800);
        stop_test();
    end
endmodule : sbx_sub_exec_test
